/* File: verilog/spc_pkg.sv */
// constants for the per-port switch control and statistics block
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - a disabled port neither sends nor accepts frames; enabled ports with link up forward
// - each port reports link up or down and its media type
// - count frames sent without error per port
// - count bad sent frames: short, oversize, crc/align, fragments, jabbers
// - count error-free received frames per port
// - count bad received frames: short, oversize, crc, fragments, jabbers
// - count frames whose transmission was aborted part way
// - count frames that met a collision on the link
// - count frames discarded by the switch on that port
// - count received broadcast frames
// - count received multicast frames
// - one clear request zeroes every counter of every port
// - automatic mode takes speed and duplex from autonegotiation
// - forced mode runs at the configured speed and duplex
// - speed and duplex are writable only in forced mode
// - with flow control on, overload sends a pause frame request
// - with flow control off, overload discards the excess frames
// - with security on, unknown source addresses are blocked
//////////////////////////////////////////////////////////////////////////////
package spc_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NCNT = 9;
  // register byte addresses
  localparam logic [11:0] CFG_BASE = 12'h000;
  localparam logic [11:0] STAT_BASE = 12'h020;
  localparam logic [11:0] CLEAR_ADDR = 12'h040;
  localparam logic [11:0] IRQ_ST_ADDR = 12'h044;
  localparam logic [11:0] IRQ_MASK_ADDR = 12'h048;
  localparam logic [11:0] CNT_BASE = 12'h200;
  // configuration word fields
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_AUTO_BIT = 1;
  localparam int CFG_SPD_BIT = 2;
  localparam int CFG_DUP_BIT = 3;
  localparam int CFG_FC_BIT = 4;
  localparam int CFG_SEC_BIT = 5;
  // status word fields
  localparam int ST_LINK_BIT = 0;
  localparam int ST_FX_BIT = 1;
  localparam int ST_SPD_BIT = 2;
  localparam int ST_DUP_BIT = 3;
  // reset values: enabled, auto, 100 full, flow on, security off
  localparam logic CFG_EN_RST = 1'b1;
  localparam logic CFG_AUTO_RST = 1'b1;
  localparam logic CFG_SPD_RST = 1'b1;
  localparam logic CFG_DUP_RST = 1'b1;
  localparam logic CFG_FC_RST = 1'b1;
  localparam logic CFG_SEC_RST = 1'b0;
  // counter index within a port
  typedef enum {
    CNT_TX_GOOD, CNT_TX_BAD, CNT_RX_GOOD, CNT_RX_BAD, CNT_TX_ABORT,
    CNT_COLL, CNT_DROP, CNT_RX_BCAST, CNT_RX_MCAST
  } spc_cnt_t;
endpackage

/* File: verilog/spc_port_ctrl.sv */
// per-port control, status, statistics counters and interrupt logic
`timescale 1ns/1ps
module spc_port_ctrl
  import spc_pkg::*;
#(
  parameter int NPORT = 6,
  parameter int CNT_W = 32
)(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [DATA_W-1:0] rd_data,
  input wire logic [NPORT-1:0] link_up,
  input wire logic [NPORT-1:0] media_fx,
  input wire logic [NPORT-1:0] an_speed_100,
  input wire logic [NPORT-1:0] an_full_dup,
  input wire logic [NPORT-1:0] tx_good,
  input wire logic [NPORT-1:0] tx_bad,
  input wire logic [NPORT-1:0] rx_good,
  input wire logic [NPORT-1:0] rx_bad,
  input wire logic [NPORT-1:0] tx_abort,
  input wire logic [NPORT-1:0] collision,
  input wire logic [NPORT-1:0] drop_in,
  input wire logic [NPORT-1:0] rx_bcast,
  input wire logic [NPORT-1:0] rx_mcast,
  input wire logic [NPORT-1:0] rx_frame,
  input wire logic [NPORT-1:0] rx_src_known,
  input wire logic [NPORT-1:0] rx_overload,
  output logic [NPORT-1:0] tx_en,
  output logic [NPORT-1:0] rx_en,
  output logic [NPORT-1:0] rx_accept,
  output logic [NPORT-1:0] rx_discard,
  output logic [NPORT-1:0] pause_req,
  output logic [NPORT-1:0] an_enable,
  output logic [NPORT-1:0] speed_100,
  output logic [NPORT-1:0] full_dup,
  output logic irq
);
  // the port field of an address is three bits wide
  if (NPORT < 1 || NPORT > 8 || CNT_W < 1 || CNT_W > DATA_W)
  begin : g_bad_param
    $error("spc_port_ctrl: unsupported NPORT or CNT_W");
  end

  //////////////////////////////////////////////////////////////////////////////
  logic [NPORT-1:0] en_reg, auto_reg, spd_reg, dup_reg, fc_reg, sec_reg;
  logic [NPORT-1:0] link_reg, ovl_reg, irq_st_reg, irq_mask_reg;
  logic [NPORT-1:0] tx_en_reg, rx_en_reg, acc_reg, disc_reg, pause_reg;
  logic [NPORT-1:0] spd_act_reg, dup_act_reg;
  logic [DATA_W-1:0] rd_reg;
  logic irq_reg;
  logic [CNT_W-1:0] cnt_reg [NPORT*NCNT];
  logic [NPORT-1:0] blk, ovl_drop, fr_ok, link_chg;
  logic [NCNT-1:0] evt [NPORT];
  logic cfg_wr, clr_wr;
  logic [2:0] wr_port;

  assign wr_port = addr[4:2];
  assign cfg_wr = wr_stb && addr[11:5] == CFG_BASE[11:5]
                  && 32'(wr_port) < NPORT;
  assign clr_wr = wr_stb && addr == CLEAR_ADDR && wr_data[0];
  assign link_chg = link_up ^ link_reg;

  // receive decision for a frame presented on the port
  assign blk = sec_reg & ~rx_src_known;
  assign ovl_drop = rx_overload & ~fc_reg;
  assign fr_ok = rx_frame & en_reg & ~blk & ~ovl_drop;

  //////////////////////////////////////////////////////////////////////////////
  // configuration; speed and duplex only taken when the write leaves auto off
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      en_reg <= {NPORT{CFG_EN_RST}};
      auto_reg <= {NPORT{CFG_AUTO_RST}};
      spd_reg <= {NPORT{CFG_SPD_RST}};
      dup_reg <= {NPORT{CFG_DUP_RST}};
      fc_reg <= {NPORT{CFG_FC_RST}};
      sec_reg <= {NPORT{CFG_SEC_RST}};
    end
    else if (cfg_wr)
    begin
      en_reg[wr_port] <= wr_data[CFG_EN_BIT];
      auto_reg[wr_port] <= wr_data[CFG_AUTO_BIT];
      fc_reg[wr_port] <= wr_data[CFG_FC_BIT];
      sec_reg[wr_port] <= wr_data[CFG_SEC_BIT];
      if (!wr_data[CFG_AUTO_BIT])
      begin
        spd_reg[wr_port] <= wr_data[CFG_SPD_BIT];
        dup_reg[wr_port] <= wr_data[CFG_DUP_BIT];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // port gating, link mode and frame decisions
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_en_reg <= '0;
      rx_en_reg <= '0;
      acc_reg <= '0;
      disc_reg <= '0;
      pause_reg <= '0;
      ovl_reg <= '0;
      link_reg <= '0;
      spd_act_reg <= '0;
      dup_act_reg <= '0;
    end
    else
    begin
      tx_en_reg <= en_reg & link_up;
      rx_en_reg <= en_reg & link_up;
      acc_reg <= fr_ok;
      disc_reg <= rx_frame & en_reg & (blk | ovl_drop);
      // one request per overload onset; repeats need a fresh onset
      pause_reg <= rx_overload & ~ovl_reg & fc_reg & en_reg;
      ovl_reg <= rx_overload;
      link_reg <= link_up;
      for (int p = 0; p < NPORT; p++)
      begin
        spd_act_reg[p] <= auto_reg[p] ? an_speed_100[p] : spd_reg[p];
        dup_act_reg[p] <= auto_reg[p] ? an_full_dup[p] : dup_reg[p];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // statistics; events count only on an enabled port
  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
    begin
      evt[p] = '0;
      evt[p][CNT_TX_GOOD] = tx_good[p];
      evt[p][CNT_TX_BAD] = tx_bad[p];
      evt[p][CNT_RX_GOOD] = rx_good[p];
      evt[p][CNT_RX_BAD] = rx_bad[p];
      evt[p][CNT_TX_ABORT] = tx_abort[p];
      evt[p][CNT_COLL] = collision[p];
      evt[p][CNT_DROP] = drop_in[p]
                         | (rx_frame[p] & (blk[p] | ovl_drop[p]));
      evt[p][CNT_RX_BCAST] = rx_bcast[p];
      evt[p][CNT_RX_MCAST] = rx_mcast[p];
      if (!en_reg[p])
        evt[p] = '0;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < NPORT*NCNT; i++)
        cnt_reg[i] <= '0;
    end
    else if (clr_wr)
    begin
      for (int i = 0; i < NPORT*NCNT; i++)
        cnt_reg[i] <= '0;
    end
    else
    begin
      // counters wrap at full scale rather than saturate
      for (int p = 0; p < NPORT; p++)
        for (int c = 0; c < NCNT; c++)
          if (evt[p][c])
            cnt_reg[p*NCNT+c] <= cnt_reg[p*NCNT+c] + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupts on link change; the set wins over a write-one clear
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_st_reg <= '0;
      irq_mask_reg <= '0;
      irq_reg <= 1'b0;
    end
    else
    begin
      if (wr_stb && addr == IRQ_ST_ADDR)
        irq_st_reg <= (irq_st_reg & ~wr_data[NPORT-1:0]) | link_chg;
      else
        irq_st_reg <= irq_st_reg | link_chg;
      if (wr_stb && addr == IRQ_MASK_ADDR)
        irq_mask_reg <= wr_data[NPORT-1:0];
      irq_reg <= |(irq_st_reg & irq_mask_reg);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read port: data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rd_reg <= '0;
    else
    begin
      rd_reg <= '0;
      if (rd_stb)
      begin
        if (addr[11:5] == CFG_BASE[11:5] && 32'(addr[4:2]) < NPORT)
        begin
          rd_reg[CFG_EN_BIT] <= en_reg[addr[4:2]];
          rd_reg[CFG_AUTO_BIT] <= auto_reg[addr[4:2]];
          rd_reg[CFG_SPD_BIT] <= spd_reg[addr[4:2]];
          rd_reg[CFG_DUP_BIT] <= dup_reg[addr[4:2]];
          rd_reg[CFG_FC_BIT] <= fc_reg[addr[4:2]];
          rd_reg[CFG_SEC_BIT] <= sec_reg[addr[4:2]];
        end
        else if (addr[11:5] == STAT_BASE[11:5] && 32'(addr[4:2]) < NPORT)
        begin
          rd_reg[ST_LINK_BIT] <= link_reg[addr[4:2]];
          rd_reg[ST_FX_BIT] <= media_fx[addr[4:2]];
          rd_reg[ST_SPD_BIT] <= spd_act_reg[addr[4:2]];
          rd_reg[ST_DUP_BIT] <= dup_act_reg[addr[4:2]];
        end
        else if (addr == IRQ_ST_ADDR)
          rd_reg[NPORT-1:0] <= irq_st_reg;
        else if (addr == IRQ_MASK_ADDR)
          rd_reg[NPORT-1:0] <= irq_mask_reg;
        else if (addr[11:9] == CNT_BASE[11:9]
                 && 32'(addr[8:6]) < NPORT && 32'(addr[5:2]) < NCNT)
          rd_reg[CNT_W-1:0] <= cnt_reg[32'(addr[8:6])*NCNT
                                       + 32'(addr[5:2])];
      end
    end
  end

  assign rd_data = rd_reg;
  assign tx_en = tx_en_reg;
  assign rx_en = rx_en_reg;
  assign rx_accept = acc_reg;
  assign rx_discard = disc_reg;
  assign pause_req = pause_reg;
  assign an_enable = auto_reg;
  assign speed_100 = spd_act_reg;
  assign full_dup = dup_act_reg;
  assign irq = irq_reg;

  //////////////////////////////////////////////////////////////////////////////
  a_tx_gate_off: assert property (
    @(posedge clk) disable iff (!rstn)
    ##1 (tx_en_reg & ~$past(en_reg)) == '0)
    else $error("disabled port enabled for transmit");

  a_rx_no_accept: assert property (
    @(posedge clk) disable iff (!rstn)
    ##1 (acc_reg & ~$past(en_reg)) == '0)
    else $error("disabled port accepted a frame");

  a_rx_gate_off: assert property (
    @(posedge clk) disable iff (!rstn)
    ##1 (rx_en_reg & ~$past(en_reg)) == '0)
    else $error("disabled port enabled for receive");

  a_clear_all: assert property (
    @(posedge clk) disable iff (!rstn)
    clr_wr |=> cnt_reg[0] == '0 && cnt_reg[NPORT*NCNT-1] == '0)
    else $error("clear left a counter nonzero");

  // per-port checks; every port is watched, since tests drive several
  for (genvar p = 0; p < NPORT; p++)
  begin : g_port_chk
    a_sec_block: assert property (
      @(posedge clk) disable iff (!rstn)
      (rx_frame[p] && sec_reg[p] && !rx_src_known[p] && en_reg[p])
      |=> !acc_reg[p] && disc_reg[p])
      else $error("unknown source not blocked");

    a_ok_accept: assert property (
      @(posedge clk) disable iff (!rstn)
      (rx_frame[p] && en_reg[p] && !blk[p] && !ovl_drop[p])
      |=> rx_accept[p] && !rx_discard[p])
      else $error("clean frame on enabled port not accepted");

    a_ovl_discard: assert property (
      @(posedge clk) disable iff (!rstn)
      (rx_frame[p] && rx_overload[p] && !fc_reg[p] && en_reg[p])
      |=> disc_reg[p] && !pause_reg[p])
      else $error("overload without flow control not discarded");

    a_fc_no_pause: assert property (
      @(posedge clk) disable iff (!rstn)
      !fc_reg[p] |=> !pause_req[p])
      else $error("pause request with flow control off");

    a_pause_onset: assert property (
      @(posedge clk) disable iff (!rstn)
      ($rose(rx_overload[p]) && fc_reg[p] && en_reg[p])
      |=> pause_req[p] ##1 !pause_req[p])
      else $error("pause request missing or not a pulse");

    a_txg_step: assert property (
      @(posedge clk) disable iff (!rstn)
      (evt[p][CNT_TX_GOOD] && !clr_wr)
      |=> cnt_reg[p*NCNT+CNT_TX_GOOD]
          == $past(cnt_reg[p*NCNT+CNT_TX_GOOD]) + 1'b1)
      else $error("good transmit counter did not step by one");

    a_rxg_step: assert property (
      @(posedge clk) disable iff (!rstn)
      (evt[p][CNT_RX_GOOD] && !clr_wr)
      |=> cnt_reg[p*NCNT+CNT_RX_GOOD]
          == $past(cnt_reg[p*NCNT+CNT_RX_GOOD]) + 1'b1)
      else $error("good receive counter did not step by one");

    a_bcast_step: assert property (
      @(posedge clk) disable iff (!rstn)
      (evt[p][CNT_RX_BCAST] && !clr_wr)
      |=> cnt_reg[p*NCNT+CNT_RX_BCAST]
          == $past(cnt_reg[p*NCNT+CNT_RX_BCAST]) + 1'b1)
      else $error("broadcast counter did not step by one");

    a_drop_step: assert property (
      @(posedge clk) disable iff (!rstn)
      (rx_frame[p] && en_reg[p] && (blk[p] || ovl_drop[p]) && !clr_wr)
      |=> cnt_reg[p*NCNT+CNT_DROP]
          == $past(cnt_reg[p*NCNT+CNT_DROP]) + 1'b1)
      else $error("refused frame not counted as dropped");

    a_cnt_hold: assert property (
      @(posedge clk) disable iff (!rstn)
      (!evt[p][CNT_RX_MCAST] && !clr_wr)
      |=> $stable(cnt_reg[p*NCNT+CNT_RX_MCAST]))
      else $error("counter changed without an event");

    a_off_no_count: assert property (
      @(posedge clk) disable iff (!rstn)
      (!en_reg[p] && !clr_wr) |=> $stable(cnt_reg[p*NCNT+CNT_TX_GOOD]))
      else $error("disabled port counted a frame");

    a_forced_mode: assert property (
      @(posedge clk) disable iff (!rstn)
      !auto_reg[p] |=> speed_100[p] == $past(spd_reg[p])
                       && full_dup[p] == $past(dup_reg[p]))
      else $error("forced mode ignores configured speed or duplex");

    a_auto_mode: assert property (
      @(posedge clk) disable iff (!rstn)
      auto_reg[p] |=> speed_100[p] == $past(an_speed_100[p])
                      && full_dup[p] == $past(an_full_dup[p]))
      else $error("auto mode ignores negotiated speed or duplex");

    a_auto_ro: assert property (
      @(posedge clk) disable iff (!rstn)
      (cfg_wr && wr_port == 3'(p) && wr_data[CFG_AUTO_BIT])
      |=> $stable(spd_reg[p]) && $stable(dup_reg[p]))
      else $error("speed written in auto mode");

    a_link_set: assert property (
      @(posedge clk) disable iff (!rstn)
      link_chg[p] |=> irq_st_reg[p])
      else $error("link change did not set its status bit");
  end

  a_link_read: assert property (
    @(posedge clk) disable iff (!rstn)
    (rd_stb && addr == STAT_BASE)
    |=> rd_data[ST_LINK_BIT] == $past(link_reg[0])
        && rd_data[ST_FX_BIT] == $past(media_fx[0]))
    else $error("status read shows wrong link or media");

  a_rd_idle: assert property (
    @(posedge clk) disable iff (!rstn)
    !rd_stb |=> rd_data == '0)
    else $error("read data not zero outside a read");

  a_irq_level: assert property (
    @(posedge clk) disable iff (!rstn)
    ##1 irq == |($past(irq_st_reg) & $past(irq_mask_reg)))
    else $error("interrupt output does not follow unmasked status");
endmodule

/* File: tb/spc_link_partner.sv */
// remote station model: frame event pulses towards one port at a time
`timescale 1ns/1ps
module spc_link_partner #(
  parameter int NPORT = 6
)(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ev_go,
  input wire logic [3:0] ev_sel,
  input wire logic [2:0] ev_port,
  output logic [NPORT-1:0] ev_line [10]
);
  //////////////////////////////////////////////////////////////////////////
  // lines 0..8 follow the counter order, line 9 is the frame arrival
  // every pulse is one cycle, so one request can never count twice
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < 10; i++) ev_line[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < 10; i++) ev_line[i] <= '0;
      if (ev_go)
        ev_line[ev_sel][ev_port] <= 1'b1;
    end
  end
endmodule

/* File: tb/switch_port_control_stats_bench.sv */
// self-checking bench for the port control and statistics block
`timescale 1ns/1ps
module switch_port_control_stats_bench
  import spc_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wr_data = '0;
  logic [DATA_W-1:0] rd_data;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [5:0] link_up = 6'h03;
  logic [5:0] media_fx = 6'h30;
  logic [5:0] an_speed_100 = 6'h3f;
  logic [5:0] an_full_dup = 6'h3f;
  logic [5:0] rx_src_known = 6'h00;
  logic [5:0] rx_overload = 6'h00;
  logic [5:0] tx_en, rx_en, rx_accept, rx_discard, pause_req;
  logic [5:0] an_enable, speed_100, full_dup;
  logic irq;
  logic ev_go = 1'b0;
  logic [3:0] ev_sel = 4'h0;
  logic [2:0] ev_port = 3'h0;
  logic [5:0] ev_line [10];
  int err_count = 0;
  int tests_run = 0;
  logic a, x;
  //////////////////////////////////////////////////////////////////////////
  spc_port_ctrl #(.NPORT(6), .CNT_W(32)) spc_port_ctrl_i (
    .clk(clk), .rstn(rstn), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .link_up(link_up), .media_fx(media_fx),
    .an_speed_100(an_speed_100), .an_full_dup(an_full_dup),
    .tx_good(ev_line[0]), .tx_bad(ev_line[1]), .rx_good(ev_line[2]),
    .rx_bad(ev_line[3]), .tx_abort(ev_line[4]), .collision(ev_line[5]),
    .drop_in(ev_line[6]), .rx_bcast(ev_line[7]), .rx_mcast(ev_line[8]),
    .rx_frame(ev_line[9]), .rx_src_known(rx_src_known),
    .rx_overload(rx_overload), .tx_en(tx_en), .rx_en(rx_en),
    .rx_accept(rx_accept), .rx_discard(rx_discard),
    .pause_req(pause_req), .an_enable(an_enable),
    .speed_100(speed_100), .full_dup(full_dup), .irq(irq));
  spc_link_partner #(.NPORT(6)) spc_link_partner_i (
    .clk(clk), .rstn(rstn), .ev_go(ev_go), .ev_sel(ev_sel),
    .ev_port(ev_port), .ev_line(ev_line));
  always #10 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [11:0] ca(input int p, input int c);
    return CNT_BASE + 12'(p) * 12'h040 + 12'(c) * 12'h004;
  endfunction
  function automatic logic [11:0] cfg(input int p);
    return CFG_BASE + 12'(p) * 12'h004;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a_i, input logic [31:0] d_i);
    @(posedge clk);
    addr <= a_i;
    wr_data <= d_i;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdchk(input logic [11:0] a_i, input logic [31:0] exp);
    @(posedge clk);
    addr <= a_i;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(negedge clk);
    chk(rd_data, exp);
  endtask
  task automatic ev(input int s, input int p);
    @(posedge clk);
    ev_go <= 1'b1;
    ev_sel <= 4'(s);
    ev_port <= 3'(p);
    @(posedge clk);
    ev_go <= 1'b0;
  endtask
  task automatic frame(input int p, output logic acc, output logic dis);
    ev(9, p);
    @(posedge clk);
    @(negedge clk);
    acc = rx_accept[p];
    dis = rx_discard[p];
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // a hang ends the run as a failure
  initial
  begin
    tick(20000);
    err_count++;
    tally_and_finish;
  end
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    tick(10);
    rstn <= 1'b1;
    rdchk(cfg(0), 32'h0000001f);
    rdchk(STAT_BASE, 32'h0000000d);
    rdchk(STAT_BASE + 12'h014, 32'h0000000e);
    rdchk(12'h100, 32'h0);
    $display("test reset and status done");
    for (int c = 0; c < NCNT; c++)
    begin
      for (int k = 0; k <= c; k++) ev(c, 1);
      rdchk(ca(1, c), 32'(c + 1));
      ev(c, 1);
      rdchk(ca(1, c), 32'(c + 2));
    end
    wr(CLEAR_ADDR, 32'h1);
    for (int c = 0; c < NCNT; c++) rdchk(ca(1, c), 32'h0);
    $display("test counters done");
    wr(cfg(1), 32'h1e);
    tick(3);
    @(negedge clk);
    chk(32'({tx_en[1], rx_en[1]}), 32'h0);
    ev(0, 1);
    frame(1, a, x);
    chk(32'({a, x}), 32'h0);
    rdchk(ca(1, 0), 32'h0);
    wr(cfg(1), 32'h1f);
    tick(3);
    @(negedge clk);
    chk(32'({tx_en[1], rx_en[1]}), 32'h3);
    frame(1, a, x);
    chk(32'({a, x}), 32'h2);
    $display("test port state done");
    wr(cfg(1), 32'h11);
    tick(3);
    @(negedge clk);
    chk(32'({an_enable[1], speed_100[1], full_dup[1]}), 32'h0);
    rdchk(cfg(1), 32'h11);
    rdchk(STAT_BASE + 12'h004, 32'h1);
    wr(cfg(1), 32'h1f);
    rdchk(cfg(1), 32'h13);
    tick(2);
    @(negedge clk);
    chk(32'({an_enable[1], speed_100[1], full_dup[1]}), 32'h7);
    $display("test negotiation done");
    wr(cfg(2), 32'h3f);
    frame(2, a, x);
    chk(32'({a, x}), 32'h1);
    rdchk(ca(2, CNT_DROP), 32'h1);
    @(posedge clk);
    rx_src_known <= 6'h04;
    frame(2, a, x);
    chk(32'({a, x}), 32'h2);
    $display("test security done");
    @(posedge clk);
    rx_overload <= 6'h08;
    @(posedge clk);
    @(negedge clk);
    chk(32'(pause_req[3]), 32'h1);
    wr(cfg(3), 32'h0f);
    frame(3, a, x);
    chk(32'({a, x}), 32'h1);
    rdchk(ca(3, CNT_DROP), 32'h1);
    $display("test flow control done");
    wr(IRQ_ST_ADDR, 32'h3f);
    @(posedge clk);
    link_up <= 6'h13;
    tick(3);
    @(negedge clk);
    chk(32'(irq), 32'h0);
    rdchk(IRQ_ST_ADDR, 32'h10);
    wr(IRQ_MASK_ADDR, 32'h10);
    tick(2);
    @(negedge clk);
    chk(32'(irq), 32'h1);
    wr(IRQ_ST_ADDR, 32'h10);
    tick(2);
    @(negedge clk);
    chk(32'(irq), 32'h0);
    $display("test interrupt done");
    tally_and_finish;
  end
endmodule
